/* File: verilog/flp_lock_protect.sv */
/*
  Flash command unit protection logic: lock-bit reads, entry protection,
  lock-bit protection with cancel bit, boot-area rules and command lock.
  Assumes a single AHB-Lite master, hclk at 10 MHz and boot_mode pins
  that are stable around reset release.
*/
`timescale 1ns/1ns

// How it works
// - Byte 71h as first command cycle with read-target select 0 enters lock-bit read mode.
// - In lock-bit read mode a read of a user-area program/erase address returns that block's lock bit on every data bit.
// - Byte 71h with read-target select 1 waits for a second cycle of D0h, which software must send.
// - The D0h cycle after that copies the addressed block's lock bit into the lock status copy bit.
// - Suspend works in a suspension-priority mode or an erasure-priority mode chosen by a config bit.
// - Program or erase against software protection is an error and locks the command unit.
// - With the entry enable bit 0 the array is read-only and takes no commands.
// - A command in read-only mode raises an illegal-command error and locks the command unit.
// - Each user-area block has a lock bit, and with cancel 0 a block whose lock bit is 0 is not changed.
// - A command that breaks lock-bit protection raises a program/erase error and locks the command unit.
// - The user boot area is changed only in serial boot, USB boot or programmer mode.
// - In serial or USB boot mode all areas are erased right after start-up, then commands are allowed.
module flp_lock_protect #(
  parameter int NUM_BLOCKS = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [2:0] boot_mode,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);

  localparam int BLK_W = $clog2(NUM_BLOCKS);

  flp_pkg::flp_phase_type dp;
  flp_pkg::flp_state_type state;
  logic pe_entry_enable;
  logic lock_protect_cancel;
  logic read_target_select;
  logic suspend_priority;
  logic [NUM_BLOCKS-1:0] lock_bits;
  logic [flp_pkg::IRQ_W-1:0] irq_stat;
  logic [flp_pkg::IRQ_W-1:0] irq_mask;
  logic lock_status_copy;
  logic cmd_locked;
  logic illegal_err;
  logic pe_err;
  logic suspend_pending;
  logic [flp_pkg::CNT_W-1:0] op_cnt;
  logic [2:0] boot_mode_q;
  logic boot_captured;
  logic boot_erasing;
  logic [flp_pkg::CNT_W-1:0] boot_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // Decode of the data phase

  logic reg_we;
  logic cmd_we;
  logic [7:0] cmd_byte;
  logic [7:0] reg_ofs;
  logic [BLK_W-1:0] cmd_blk;
  logic cmd_boot_area;
  logic boot_ok;
  logic cmd_blk_lock;
  logic ev_illegal;
  logic ev_pe_err;
  logic ev_done;
  logic [31:0] next_hrdata;
  logic [BLK_W-1:0] rd_blk;

  assign reg_we = dp.valid && dp.write && dp.addr[31:20] == flp_pkg::WIN_REGS;
  assign cmd_we = dp.valid && dp.write &&
                  (dp.addr[31:20] == flp_pkg::WIN_USER_PE || dp.addr[31:20] == flp_pkg::WIN_BOOT_PE);
  assign cmd_byte = hwdata[7:0];
  assign reg_ofs = dp.addr[7:0];
  assign cmd_blk = dp.addr[19 -: BLK_W];
  assign cmd_boot_area = dp.addr[31:20] == flp_pkg::WIN_BOOT_PE;
  assign cmd_blk_lock = lock_bits[cmd_blk];
  assign rd_blk = haddr[19 -: BLK_W];
  assign boot_ok = boot_mode_q == flp_pkg::BM_SERIAL_BOOT || boot_mode_q == flp_pkg::BM_USB_BOOT ||
                   boot_mode_q == flp_pkg::BM_PROGRAMMER;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp.valid <= hsel && hready && htrans[1];
      dp.write <= hwrite;
      dp.addr <= haddr;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_comb
  begin
    next_hrdata = 32'h0000_0000;
    if (haddr[31:20] == flp_pkg::WIN_REGS)
    begin
      unique case (haddr[7:0])
        flp_pkg::OFS_ENTRY: next_hrdata[0] = pe_entry_enable;
        flp_pkg::OFS_PROTECT: next_hrdata[0] = lock_protect_cancel;
        flp_pkg::OFS_CONFIG:
        begin
          next_hrdata[flp_pkg::CFG_RTS] = read_target_select;
          next_hrdata[flp_pkg::CFG_SUSP_PRIO] = suspend_priority;
        end
        flp_pkg::OFS_STATUS1:
        begin
          next_hrdata[flp_pkg::ST_LOCK_COPY] = lock_status_copy;
          next_hrdata[flp_pkg::ST_LOCKED] = cmd_locked;
          next_hrdata[flp_pkg::ST_ILLEGAL] = illegal_err;
          next_hrdata[flp_pkg::ST_PE_ERR] = pe_err;
          next_hrdata[flp_pkg::ST_BUSY] = state == flp_pkg::ST_BUSY_S;
          next_hrdata[flp_pkg::ST_SUSPENDED] = state == flp_pkg::ST_SUSPEND_S;
          next_hrdata[flp_pkg::ST_LOCK_READ] = state == flp_pkg::ST_LOCKREAD_S;
          next_hrdata[flp_pkg::ST_WAIT_CONF] = state == flp_pkg::ST_WAITCONF_S;
          next_hrdata[flp_pkg::ST_BOOT_ERASING] = boot_erasing;
        end
        flp_pkg::OFS_IRQ_STAT: next_hrdata[flp_pkg::IRQ_W-1:0] = irq_stat;
        flp_pkg::OFS_IRQ_MASK: next_hrdata[flp_pkg::IRQ_W-1:0] = irq_mask;
        flp_pkg::OFS_LOCKBITS: next_hrdata[NUM_BLOCKS-1:0] = lock_bits;
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
    else if (haddr[31:20] == flp_pkg::WIN_USER_PE && state == flp_pkg::ST_LOCKREAD_S)
      next_hrdata = {32{lock_bits[rd_blk]}};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (hsel && hready && htrans[1] && !hwrite)
      hrdata <= next_hrdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pe_entry_enable <= 1'b0;
      lock_protect_cancel <= 1'b0;
      read_target_select <= 1'b0;
      suspend_priority <= 1'b0;
      irq_mask <= '0;
    end
    else if (reg_we)
    begin
      unique case (reg_ofs)
        flp_pkg::OFS_ENTRY: pe_entry_enable <= hwdata[0];
        flp_pkg::OFS_PROTECT: lock_protect_cancel <= hwdata[0];
        flp_pkg::OFS_CONFIG:
        begin
          read_target_select <= hwdata[flp_pkg::CFG_RTS];
          suspend_priority <= hwdata[flp_pkg::CFG_SUSP_PRIO];
        end
        flp_pkg::OFS_IRQ_MASK: irq_mask <= hwdata[flp_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Lock bits: software writable, set by the start-up erase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lock_bits <= flp_pkg::LOCKBITS_RESET[NUM_BLOCKS-1:0];
    else if (boot_erasing && boot_cnt == 8'h01)
      lock_bits <= '1;
    else if (reg_we && reg_ofs == flp_pkg::OFS_LOCKBITS)
      lock_bits <= hwdata[NUM_BLOCKS-1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Boot mode capture and start-up erase

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      boot_mode_q <= flp_pkg::BM_USER_PROG;
      boot_captured <= 1'b0;
      boot_erasing <= 1'b0;
      boot_cnt <= '0;
    end
    else if (!boot_captured)
    begin
      boot_mode_q <= boot_mode;
      boot_captured <= 1'b1;
      boot_erasing <= boot_mode == flp_pkg::BM_SERIAL_BOOT || boot_mode == flp_pkg::BM_USB_BOOT;
      boot_cnt <= flp_pkg::CNT_W'(flp_pkg::BOOT_ERASE_CYCLES);
    end
    else if (boot_erasing)
    begin
      boot_cnt <= boot_cnt - 8'h01;
      boot_erasing <= boot_cnt != 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command engine

  always_comb
  begin
    ev_illegal = 1'b0;
    ev_pe_err = 1'b0;
    if (cmd_we)
    begin
      if (!pe_entry_enable || boot_erasing)
        ev_illegal = 1'b1;
      else if (!cmd_locked)
      begin
        unique case (state)
          flp_pkg::ST_WAITCONF_S: ev_illegal = cmd_byte != flp_pkg::CMD_CONFIRM;
          flp_pkg::ST_BUSY_S: ev_illegal = cmd_byte != flp_pkg::CMD_SUSPEND;
          flp_pkg::ST_SUSPEND_S: ev_illegal = cmd_byte != flp_pkg::CMD_CONFIRM;
          flp_pkg::ST_READY_S, flp_pkg::ST_LOCKREAD_S:
          begin
            if (cmd_byte == flp_pkg::CMD_PROGRAM || cmd_byte == flp_pkg::CMD_ERASE)
              ev_pe_err = cmd_boot_area ? !boot_ok : (!cmd_blk_lock && !lock_protect_cancel);
            else
              ev_illegal = !(cmd_byte == flp_pkg::CMD_LOCK_READ || cmd_byte == flp_pkg::CMD_READ_MODE ||
                             cmd_byte == flp_pkg::CMD_STATUS_CLR);
          end
        endcase
      end
    end
  end

  // Completion only on a cycle the state machine counts, never under a command write
  assign ev_done = state == flp_pkg::ST_BUSY_S && op_cnt == 8'h01 && !suspend_pending && !cmd_we;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= flp_pkg::ST_READY_S;
      op_cnt <= '0;
      suspend_pending <= 1'b0;
      lock_status_copy <= 1'b0;
      cmd_locked <= 1'b0;
      illegal_err <= 1'b0;
      pe_err <= 1'b0;
    end
    else if (ev_illegal || ev_pe_err)
    begin
      cmd_locked <= 1'b1;
      illegal_err <= illegal_err | ev_illegal;
      pe_err <= pe_err | ev_pe_err;
      if (state == flp_pkg::ST_WAITCONF_S)
        state <= flp_pkg::ST_READY_S;
    end
    else if (cmd_we && cmd_locked)
    begin
      if (cmd_byte == flp_pkg::CMD_STATUS_CLR)
      begin
        cmd_locked <= 1'b0;
        illegal_err <= 1'b0;
        pe_err <= 1'b0;
      end
    end
    else if (cmd_we)
    begin
      unique case (state)
        flp_pkg::ST_WAITCONF_S:
        begin
          lock_status_copy <= cmd_blk_lock;
          state <= flp_pkg::ST_READY_S;
        end
        flp_pkg::ST_BUSY_S:
        begin
          if (suspend_priority)
            state <= flp_pkg::ST_SUSPEND_S;
          else
            suspend_pending <= 1'b1;
        end
        flp_pkg::ST_SUSPEND_S: state <= flp_pkg::ST_BUSY_S;
        flp_pkg::ST_READY_S, flp_pkg::ST_LOCKREAD_S:
        begin
          if (cmd_byte == flp_pkg::CMD_LOCK_READ)
            state <= read_target_select ? flp_pkg::ST_WAITCONF_S : flp_pkg::ST_LOCKREAD_S;
          else if (cmd_byte == flp_pkg::CMD_READ_MODE)
            state <= flp_pkg::ST_READY_S;
          else if (cmd_byte == flp_pkg::CMD_STATUS_CLR)
          begin
            illegal_err <= 1'b0;
            pe_err <= 1'b0;
          end
          else
          begin
            state <= flp_pkg::ST_BUSY_S;
            op_cnt <= flp_pkg::CNT_W'(flp_pkg::PE_CYCLES);
          end
        end
      endcase
    end
    else if (state == flp_pkg::ST_BUSY_S)
    begin
      if (suspend_pending && op_cnt <= flp_pkg::CNT_W'(flp_pkg::PE_CYCLES / 2))
      begin
        state <= flp_pkg::ST_SUSPEND_S;
        suspend_pending <= 1'b0;
      end
      else if (ev_done)
        state <= flp_pkg::ST_READY_S;
      else
        op_cnt <= op_cnt - 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [flp_pkg::IRQ_W-1:0] irq_events;
  assign irq_events = {ev_done, ev_pe_err, ev_illegal};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_stat <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (reg_we && reg_ofs == flp_pkg::OFS_IRQ_STAT)
        irq_stat <= (irq_stat & ~hwdata[flp_pkg::IRQ_W-1:0]) | irq_events;
      else
        irq_stat <= irq_stat | irq_events;
      irq <= |(irq_stat & irq_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_lock_read_entry;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && pe_entry_enable && !cmd_locked && !boot_erasing && state == flp_pkg::ST_READY_S &&
    cmd_byte == flp_pkg::CMD_LOCK_READ && !read_target_select |=> state == flp_pkg::ST_LOCKREAD_S;
  endproperty
  a_lock_read_entry: assert property (p_lock_read_entry) else $error("lock read mode not entered");

  property p_lock_read_data;
    @(posedge hclk) disable iff (!hresetn)
    hsel && hready && htrans[1] && !hwrite && haddr[31:20] == flp_pkg::WIN_USER_PE &&
    state == flp_pkg::ST_LOCKREAD_S |=> hrdata == {32{$past(lock_bits[rd_blk])}};
  endproperty
  a_lock_read_data: assert property (p_lock_read_data) else $error("lock bit read data wrong");

  property p_wait_confirm;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && pe_entry_enable && !cmd_locked && !boot_erasing && state == flp_pkg::ST_READY_S &&
    cmd_byte == flp_pkg::CMD_LOCK_READ && read_target_select |=> state == flp_pkg::ST_WAITCONF_S;
  endproperty
  a_wait_confirm: assert property (p_wait_confirm) else $error("no wait for confirm cycle");

  property p_lock_copy;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && state == flp_pkg::ST_WAITCONF_S && !ev_illegal && !cmd_locked
      |=> lock_status_copy == $past(cmd_blk_lock) && state == flp_pkg::ST_READY_S;
  endproperty
  a_lock_copy: assert property (p_lock_copy) else $error("lock status not copied");

  property p_suspend_prio;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && state == flp_pkg::ST_BUSY_S && !ev_illegal && !cmd_locked && suspend_priority
      |=> state == flp_pkg::ST_SUSPEND_S;
  endproperty
  a_suspend_prio: assert property (p_suspend_prio) else $error("suspend not immediate");

  property p_readonly;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && !pe_entry_enable |=> cmd_locked && illegal_err && state != flp_pkg::ST_BUSY_S ##1 irq_stat[0];
  endproperty
  a_readonly: assert property (p_readonly) else $error("read-only command accepted");

  property p_lock_protect;
    @(posedge hclk) disable iff (!hresetn)
    ev_pe_err |=> cmd_locked && pe_err && $stable(op_cnt);
  endproperty
  a_lock_protect: assert property (p_lock_protect) else $error("protection error not locked");

  property p_block_refused;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && state == flp_pkg::ST_READY_S && !cmd_boot_area && !cmd_blk_lock && !lock_protect_cancel &&
    (cmd_byte == flp_pkg::CMD_PROGRAM || cmd_byte == flp_pkg::CMD_ERASE) |=> state != flp_pkg::ST_BUSY_S;
  endproperty
  a_block_refused: assert property (p_block_refused) else $error("locked block changed");

  property p_boot_area;
    @(posedge hclk) disable iff (!hresetn)
    cmd_we && pe_entry_enable && !cmd_locked && !boot_erasing && cmd_boot_area && !boot_ok &&
    state == flp_pkg::ST_READY_S && cmd_byte == flp_pkg::CMD_ERASE |=> pe_err && state == flp_pkg::ST_READY_S;
  endproperty
  a_boot_area: assert property (p_boot_area) else $error("boot area changed in wrong mode");

  property p_stay_locked;
    @(posedge hclk) disable iff (!hresetn)
    cmd_locked && !(cmd_we && pe_entry_enable && cmd_byte == flp_pkg::CMD_STATUS_CLR)
      |=> cmd_locked && state != flp_pkg::ST_BUSY_S || $past(state) == flp_pkg::ST_BUSY_S;
  endproperty
  a_stay_locked: assert property (p_stay_locked) else $error("lock released without clear");

endmodule

/* File: verilog/flp_pkg.sv */
/*
  Package for the flash lock-bit protection block: register offsets, bit
  positions, command bytes, boot-mode codes, timing and the bus carrier.
  Assumes a 10 MHz system clock and an AHB-Lite master with 32-bit data.
*/
package flp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ENTRY = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS1 = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_LOCKBITS = 8'h18;

  // Address windows, upper twelve bits
  localparam logic [11:0] WIN_REGS = 12'h400;
  localparam logic [11:0] WIN_READ = 12'h000;
  localparam logic [11:0] WIN_USER_PE = 12'h808;
  localparam logic [11:0] WIN_BOOT_PE = 12'h809;

  // Config register fields
  localparam int CFG_RTS = 0;
  localparam int CFG_SUSP_PRIO = 1;

  // Status register one fields
  localparam int ST_LOCK_COPY = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_ILLEGAL = 2;
  localparam int ST_PE_ERR = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_SUSPENDED = 5;
  localparam int ST_LOCK_READ = 6;
  localparam int ST_WAIT_CONF = 7;
  localparam int ST_BOOT_ERASING = 8;

  // Interrupt status bits
  localparam int IRQ_ILLEGAL = 0;
  localparam int IRQ_PE_ERR = 1;
  localparam int IRQ_DONE = 2;
  localparam int IRQ_W = 3;

  // Command bytes
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_PROGRAM = 8'he8;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_STATUS_CLR = 8'h50;
  localparam logic [7:0] CMD_READ_MODE = 8'hff;

  // Boot-mode pin codes
  localparam logic [2:0] BM_USER_PROG = 3'h0;
  localparam logic [2:0] BM_USER_BOOT = 3'h1;
  localparam logic [2:0] BM_SERIAL_BOOT = 3'h2;
  localparam logic [2:0] BM_USB_BOOT = 3'h3;
  localparam logic [2:0] BM_PROGRAMMER = 3'h4;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int PE_TIME_NS = 2000;
  localparam int BOOT_ERASE_TIME_NS = 10000;
  localparam int PE_CYCLES = (PE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_ERASE_CYCLES = (BOOT_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  // Reset values
  localparam logic [31:0] LOCKBITS_RESET = 32'hffff_ffff;

  typedef enum logic [2:0] {
    ST_READY_S,
    ST_LOCKREAD_S,
    ST_WAITCONF_S,
    ST_BUSY_S,
    ST_SUSPEND_S
  } flp_state_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } flp_phase_type;

endpackage

/* File: tb/flp_cpu_model.sv */
/*
  CPU model that issues single-word AHB-Lite transfers: register accesses
  and flash command writes to the protection block.
  Assumes the slave's hreadyout is fed back as hready and one clock domain.
*/
`timescale 1ns/1ns

module flp_cpu_model (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [31:0] hwdata
);

  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd_val);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    // Released data bus shows no stale value
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_val = hrdata;
  endtask

endmodule

/* File: tb/tb.sv */
/*
  Self-checking bench for the flash lock-bit protection block.
  Assumes the CPU model drives the bus and the package register map.
*/
`timescale 1ns/1ns

module tb;

  localparam logic [31:0] RB = 32'h4000_0000;
  localparam logic [31:0] UA = 32'h8080_0000;
  localparam logic [31:0] BA = 32'h8090_0000;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r, lb, a;
  logic [1:0] htrans;
  logic [2:0] boot_mode;
  logic [3:0] bk;
  int err_count, n_checks, cyc, seed, i;

  flp_lock_protect #(.NUM_BLOCKS(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .boot_mode(boot_mode),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

  flp_cpu_model m (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lock_fill(input logic [31:0] l, input logic [3:0] b);
    return {32{l[b]}};
  endfunction

  function automatic logic boot_ok(input logic [2:0] bm);
    return bm inside {flp_pkg::BM_SERIAL_BOOT, flp_pkg::BM_USB_BOOT, flp_pkg::BM_PROGRAMMER};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic rd(input logic [31:0] ad);
    m.xfer(1'b0, ad, 32'h0, r);
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] dummy;
    m.xfer(1'b1, ad, d, dummy);
  endtask

  task automatic rreg(input logic [7:0] o);
    rd({RB[31:8], o});
  endtask

  task automatic wreg(input logic [7:0] o, input logic [31:0] d);
    wr({RB[31:8], o}, d);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [31:0] ad);
    wr(ad, {24'h0, c});
  endtask

  task automatic wait_ready();
    for (int k = 0; k < 80; k++)
    begin
      rreg(flp_pkg::OFS_STATUS1);
      if (r[5:4] == 2'b00 && r[8] == 1'b0)
        break;
    end
  endtask

  task automatic do_reset(input logic [2:0] bm);
    @(posedge hclk);
    hresetn <= 1'b0;
    boot_mode <= bm;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Hang guard
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h83a3890b;
    hresetn = 1'b0;
    boot_mode = 3'h0;
    cyc = 0;
    do_reset(flp_pkg::BM_USER_PROG);
    // Reset values, entry protection, interrupt, command lock
    rreg(flp_pkg::OFS_ENTRY); chk(r, 32'h0);
    rreg(flp_pkg::OFS_PROTECT); chk(r, 32'h0);
    rreg(flp_pkg::OFS_LOCKBITS); chk(r & 32'hffff, 32'hffff);
    rreg(8'h40); chk(r, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    wreg(flp_pkg::OFS_IRQ_MASK, 32'h7);
    cmd(flp_pkg::CMD_PROGRAM, UA);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h1e, 32'h6);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wreg(flp_pkg::OFS_ENTRY, 32'h1);
    cmd(flp_pkg::CMD_PROGRAM, UA);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h16, 32'h6);
    cmd(flp_pkg::CMD_STATUS_CLR, UA);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'he, 32'h0);
    wreg(flp_pkg::OFS_IRQ_STAT, 32'h7);
    rreg(flp_pkg::OFS_IRQ_STAT); chk(r, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    $display("test entry protection done");
    // Lock-bit read mode with random lock bits
    lb = $random(seed);
    lb[31:16] = 16'hffff;
    lb[3:0] = 4'ha;
    wreg(flp_pkg::OFS_LOCKBITS, lb);
    wreg(flp_pkg::OFS_CONFIG, 32'h0);
    cmd(flp_pkg::CMD_LOCK_READ, UA);
    for (i = 0; i < 8; i++)
    begin
      bk = 4'($random(seed));
      rd(UA | {12'h0, bk, 16'h0} | (32'($random(seed)) & 32'hfffc));
      chk(r, lock_fill(lb, bk));
    end
    cmd(flp_pkg::CMD_READ_MODE, UA);
    rd(UA); chk(r, 32'h0);
    $display("test lock read one done");
    // Two-cycle lock-bit read into status copy
    wreg(flp_pkg::OFS_CONFIG, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      a = UA | (i << 16);
      cmd(flp_pkg::CMD_LOCK_READ, a);
      rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h80, 32'h80);
      cmd(flp_pkg::CMD_CONFIRM, a);
      rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h81, {31'h0, lb[i]});
    end
    wreg(flp_pkg::OFS_CONFIG, 32'h0);
    $display("test lock read two done");
    // Lock-bit protection and cancel bit
    cmd(flp_pkg::CMD_PROGRAM, UA);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h1e, 32'ha);
    rreg(flp_pkg::OFS_IRQ_STAT); chk(r & 32'h2, 32'h2);
    cmd(flp_pkg::CMD_STATUS_CLR, UA);
    wreg(flp_pkg::OFS_IRQ_STAT, 32'h7);
    cmd(flp_pkg::CMD_ERASE, UA | 32'h1_0000);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h1e, 32'h10);
    wait_ready();
    wreg(flp_pkg::OFS_PROTECT, 32'h1);
    cmd(flp_pkg::CMD_PROGRAM, UA);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h1e, 32'h10);
    wait_ready();
    rreg(flp_pkg::OFS_IRQ_STAT); chk(r & 32'h4, 32'h4);
    chk({31'h0, irq}, 32'h1);
    wreg(flp_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    wreg(flp_pkg::OFS_IRQ_MASK, 32'h7);
    wreg(flp_pkg::OFS_IRQ_STAT, 32'h7);
    wreg(flp_pkg::OFS_PROTECT, 32'h0);
    $display("test lock protection done");
    // Suspension priority, then erasure priority
    a = UA | 32'h3_0000;
    wreg(flp_pkg::OFS_CONFIG, 32'h2);
    cmd(flp_pkg::CMD_PROGRAM, a);
    cmd(flp_pkg::CMD_SUSPEND, a);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h20, 32'h20);
    cmd(flp_pkg::CMD_CONFIRM, a);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h30, 32'h10);
    wait_ready();
    wreg(flp_pkg::OFS_CONFIG, 32'h0);
    cmd(flp_pkg::CMD_ERASE, a);
    cmd(flp_pkg::CMD_SUSPEND, a);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h20, 32'h0);
    repeat (12) @(posedge hclk);
    rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h20, 32'h20);
    cmd(flp_pkg::CMD_CONFIRM, a);
    wait_ready();
    chk(r & 32'h3e, 32'h0);
    $display("test suspend done");
    // Boot modes: start-up erase and boot area access
    for (i = 0; i < 5; i++)
    begin
      do_reset(3'(i));
      rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h100, (i == 2 || i == 3) ? 32'h100 : 32'h0);
      // Clear lock bits while the start-up erase runs, so that its final set shows
      wreg(flp_pkg::OFS_LOCKBITS, 32'h0);
      wait_ready();
      rreg(flp_pkg::OFS_LOCKBITS); chk(r & 32'hffff, (i == 2 || i == 3) ? 32'hffff : 32'h0);
      wreg(flp_pkg::OFS_ENTRY, 32'h1);
      cmd(flp_pkg::CMD_PROGRAM, BA);
      rreg(flp_pkg::OFS_STATUS1); chk(r & 32'h18, boot_ok(3'(i)) ? 32'h10 : 32'h8);
      wait_ready();
    end
    $display("test boot modes done");
    final_report();
  end

endmodule
